// ---- logic/fanp_regs.sv ----
// fanp_regs: fiber auto-negotiation expansion and next-page register bank
// assumes an AXI4-Lite master on aclk, and page events as one-cycle strobes
// from the negotiation engine, synchronous to aclk
// Operation
// - base page with more-pages sets bit 3
// - any base page sets bit 0
// - negotiation enable clears bits 3 and 0
// - bit 2 is one for fiber, zero SGMII
// - any received page latches bit 1
// - reading expansion clears bit 1; 15-4 zero
// - local bit 15 says more pages follow
// - local bit 13 selects message page, resets one
// - local bit 12 says we can comply
// - local toggle bit 11 kept by hardware
// - local code bits 10-0, register resets 2001
// - partner page bits 15, 13, 12 read-only
// - partner toggle bit 11 as received
// - partner code bits 10-0, resets zero
// - control bit 15 advertises next pages
// - partner next page raises pending bit 1
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "fanp_map.svh"

module fanp_regs (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [15:0] s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  input  wire logic        sgmii_mode,
  input  wire logic        negotiation_enable_state,
  input  wire logic        page_rx_valid,
  input  wire logic        page_rx_is_base,
  input  wire logic [15:0] page_rx_word,
  input  wire logic        partner_page_ack,
  output logic             advertise_more_pages,
  output logic             tx_page_valid,
  output logic [15:0]      tx_page_word
);
  import fanp_pkg::*;

  logic              partner_np_cap_q;
  logic              partner_an_cap_q;
  logic              page_arrived_latch_q;
  logic              irq_pending_q;
  logic [15:0]       locnp_q;
  logic [15:0]       ctrl_q;
  logic [15:0]       lpnp_page;
  logic              local_toggle_q;
  logic              aw_hold_q;
  logic              w_hold_q;
  logic [15:0]       awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  fanp_sel_type      rd_sel_q;
  fanp_np_state_type np_state_q;
  fanp_np_state_type np_state_d;
  fanp_sel_type      ar_sel;
  fanp_sel_type      wr_sel;
  logic [15:0]       exp_word;
  logic [15:0]       locnp_word;
  logic [15:0]       rd_word;
  logic [15:0]       wmask;
  logic              rd_take;
  logic              wr_do;
  logic              base_rx;
  logic              next_rx;
  logic              tx_go;

  // word address decode; unmapped words fall to none
  function automatic fanp_sel_type decode(input logic [15:0] a);
    fanp_sel_type s;
    case (a[15:2])
      `FANP_IDX_EXP:   s = FANP_SEL_EXP;
      `FANP_IDX_LOCNP: s = FANP_SEL_LOCNP;
      `FANP_IDX_LPNP:  s = FANP_SEL_LPNP;
      `FANP_IDX_CTRL:  s = FANP_SEL_CTRL;
      `FANP_IDX_IRQ:   s = FANP_SEL_IRQ;
      default:         s = FANP_SEL_NONE;
    endcase
    return s;
  endfunction

  // event qualifiers; everything freezes while ce is low
  assign base_rx = ce && page_rx_valid && page_rx_is_base;
  assign next_rx = ce && page_rx_valid && !page_rx_is_base;
  assign rd_take = ce && s_axi_arvalid && s_axi_arready;
  assign wr_do   = ce && aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign ar_sel  = decode(s_axi_araddr);
  assign wr_sel  = decode(awaddr_q);
  assign wmask   = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}} & `FANP_LOCNP_WMASK;

  // expansion word; upper bits tie to zero
  always_comb begin
    exp_word = `FANP_RST_EXP;
    exp_word[`FANP_EXP_PARTNER_NP] = partner_np_cap_q;
    exp_word[`FANP_EXP_LOCAL_NP]   = !sgmii_mode;
    exp_word[`FANP_EXP_PAGE_RX]    = page_arrived_latch_q;
    exp_word[`FANP_EXP_PARTNER_AN] = partner_an_cap_q;
  end

  // local page view with the hardware toggle folded
  always_comb begin
    locnp_word = locnp_q;
    locnp_word[`FANP_NP_TOGGLE] = local_toggle_q;
  end

  // partner capability flags; a new base page in the same cycle beats the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      partner_np_cap_q <= 1'b0;
      partner_an_cap_q <= 1'b0;
    end else if (ce) begin
      if (base_rx) begin
        partner_an_cap_q <= 1'b1;
        partner_np_cap_q <= page_rx_word[`FANP_NP_MORE];
      end else if (negotiation_enable_state) begin
        partner_an_cap_q <= 1'b0;
        partner_np_cap_q <= 1'b0;
      end
    end
  end

  // page arrival latch; arrival wins over the read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      page_arrived_latch_q <= 1'b0;
    end else if (ce) begin
      if (page_rx_valid) begin
        page_arrived_latch_q <= 1'b1;
      end else if (rd_take && ar_sel == FANP_SEL_EXP) begin
        page_arrived_latch_q <= 1'b0;
      end
    end
  end

  // partner next-page pending flag, cleared by reading its register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_pending_q <= 1'b0;
    end else if (ce) begin
      if (next_rx) begin
        irq_pending_q <= 1'b1;
      end else if (rd_take && ar_sel == FANP_SEL_IRQ) begin
        irq_pending_q <= 1'b0;
      end
    end
  end

  // received next page store
  fanp_page_capture u_capture (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .capture   (next_rx),
    .page_word (page_rx_word),
    .page_q    (lpnp_page)
  );

  // software-written local page and control; byte lanes honoured
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      locnp_q <= `FANP_RST_LOCNP;
      ctrl_q  <= `FANP_RST_CTRL;
    end else if (wr_do) begin
      if (wr_sel == FANP_SEL_LOCNP) begin
        // more, mode, comply and code bits only
        locnp_q <= (locnp_q & ~wmask) | (wdata_q[15:0] & wmask);
      end else if (wr_sel == FANP_SEL_CTRL && wstrb_q[1]) begin
        ctrl_q[`FANP_CTRL_ADV_NP] <= wdata_q[`FANP_CTRL_ADV_NP];
      end
    end
  end

  // advertisement bit driven out from its flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      advertise_more_pages <= 1'b0;
    end else if (ce) begin
      advertise_more_pages <= ctrl_q[`FANP_CTRL_ADV_NP];
    end
  end

  // next-page sequencer: send only when both ends exchange pages
  assign tx_go = ce && partner_page_ack && !negotiation_enable_state &&
                 (np_state_q == FANP_NP_ACTIVE ||
                  (np_state_q == FANP_NP_IDLE && ctrl_q[`FANP_CTRL_ADV_NP] &&
                   partner_np_cap_q && !sgmii_mode));

  always_comb begin
    np_state_d = np_state_q;
    case (np_state_q)
      FANP_NP_IDLE:   if (tx_go) np_state_d = FANP_NP_ACTIVE;
      FANP_NP_ACTIVE: if (tx_go && !locnp_q[`FANP_NP_MORE]) np_state_d = FANP_NP_DONE;
      FANP_NP_DONE:   np_state_d = FANP_NP_DONE;
      default:        np_state_d = FANP_NP_IDLE;
    endcase
    if (negotiation_enable_state) begin
      np_state_d = FANP_NP_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      np_state_q <= FANP_NP_IDLE;
    end else if (ce) begin
      np_state_q <= np_state_d;
    end
  end

  // page launch; toggle flips after every page sent
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_page_valid  <= 1'b0;
      tx_page_word   <= `FANP_RST_EXP;
      local_toggle_q <= 1'b0;
    end else if (ce) begin
      tx_page_valid <= tx_go;
      if (tx_go) begin
        tx_page_word   <= locnp_word;
        local_toggle_q <= !local_toggle_q;
      end else if (negotiation_enable_state) begin
        local_toggle_q <= 1'b0;
      end
    end
  end

  // write channel: address and data held independently, answer once both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      awaddr_q      <= 16'h0000;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q     <= 1'b1;
        s_axi_awready <= 1'b0;
        awaddr_q      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q     <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        aw_hold_q     <= 1'b0;
        w_hold_q      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // write response; read-only registers accept and ignore, holes error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `FANP_RESP_OKAY;
    end else if (ce) begin
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_sel == FANP_SEL_NONE) ? `FANP_RESP_SLVERR : `FANP_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read data select; narrow words sit in the low bits
  always_comb begin
    case (ar_sel)
      FANP_SEL_EXP:   rd_word = exp_word;
      FANP_SEL_LOCNP: rd_word = locnp_word;
      FANP_SEL_LPNP:  rd_word = lpnp_page;
      FANP_SEL_CTRL:  rd_word = ctrl_q;
      FANP_SEL_IRQ:   rd_word = 16'(irq_pending_q) << `FANP_IRQ_NP_RX;
      default:        rd_word = 16'h0000;
    endcase
  end

  // read channel: one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `FANP_RESP_OKAY;
      rd_sel_q      <= FANP_SEL_NONE;
    end else if (ce) begin
      if (rd_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {16'h0000, rd_word};
        s_axi_rresp   <= (ar_sel == FANP_SEL_NONE) ? `FANP_RESP_SLVERR : `FANP_RESP_OKAY;
        rd_sel_q      <= ar_sel;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence base_with_more;
    ce && base_rx && page_rx_word[`FANP_NP_MORE];
  endsequence

  sequence exp_read_quiet;
    rd_take && ar_sel == FANP_SEL_EXP && !page_rx_valid;
  endsequence

  chk_partner_np_set: assert property (
    base_with_more |=> partner_np_cap_q && partner_an_cap_q)
    else $error("base page with more-pages did not set capability");

  chk_partner_an_set: assert property (
    base_rx |=> exp_word[`FANP_EXP_PARTNER_AN])
    else $error("base page did not set negotiation capable");

  chk_negotiation_enable_state_clear: assert property (
    ce && negotiation_enable_state && !page_rx_valid |=>
      !partner_np_cap_q && !partner_an_cap_q)
    else $error("negotiation enable left capability set");

  chk_local_np_mode: assert property (
    exp_word[`FANP_EXP_LOCAL_NP] == !sgmii_mode)
    else $error("local next-page capability wrong for mode");

  chk_page_latch: assert property (
    ce && page_rx_valid |=> page_arrived_latch_q)
    else $error("page arrival not latched");

  chk_exp_read_clear: assert property (
    exp_read_quiet |=> !page_arrived_latch_q && s_axi_rvalid &&
      s_axi_rdata[31:4] == 28'h0000000 && s_axi_rdata[1] == $past(page_arrived_latch_q))
    else $error("expansion read did not return and clear the latch");

  chk_lpnp_capture: assert property (
    next_rx |=> lpnp_page == ($past(page_rx_word) & `FANP_LPNP_MASK) &&
      !lpnp_page[`FANP_NP_RSVD])
    else $error("partner next page not captured");

  chk_irq_pending: assert property (
    next_rx |=> irq_pending_q ##0
      (ce && !page_rx_valid && !(rd_take && ar_sel == FANP_SEL_IRQ))[*2] |=> irq_pending_q)
    else $error("pending flag not held after next page");

  chk_tx_toggle_flip: assert property (
    tx_go |=> tx_page_valid && tx_page_word[`FANP_NP_TOGGLE] == $past(local_toggle_q) &&
      local_toggle_q != $past(local_toggle_q))
    else $error("sent page toggle wrong or not flipped");

  chk_local_reset_val: assert property (
    $rose(aresetn) |-> locnp_word == `FANP_RST_LOCNP)
    else $error("local page reset value wrong");

endmodule

// ---- shared/fanp_map.svh ----
// fanp_map.svh: register indices, field positions, reset values and bus codes
// for the fiber next-page register bank; definitions only, included by bare name
`ifndef FANP_MAP_SVH
`define FANP_MAP_SVH

// register indices; byte address is four times the index
`define FANP_IDX_EXP        14'h0c06
`define FANP_IDX_LOCNP      14'h0c07
`define FANP_IDX_LPNP       14'h0c08
`define FANP_IDX_CTRL       14'h0c20
`define FANP_IDX_IRQ        14'h0c21

// expansion register fields
`define FANP_EXP_PARTNER_NP 3
`define FANP_EXP_LOCAL_NP   2
`define FANP_EXP_PAGE_RX    1
`define FANP_EXP_PARTNER_AN 0

// next-page word fields
`define FANP_NP_MORE        15
`define FANP_NP_RSVD        14
`define FANP_NP_MSG_MODE    13
`define FANP_NP_COMPLY      12
`define FANP_NP_TOGGLE      11
`define FANP_NP_CODE_MSB    10

// writable bits of the local page, and the reserved bit mask of a received page
`define FANP_LOCNP_WMASK    16'hb7ff
`define FANP_LPNP_MASK      16'hbfff

// control and pending-flag fields
`define FANP_CTRL_ADV_NP    15
`define FANP_IRQ_NP_RX      1

// reset values
`define FANP_RST_EXP        16'h0000
`define FANP_RST_LOCNP      16'h2001
`define FANP_RST_LPNP       16'h0000
`define FANP_RST_CTRL       16'h0000

// response codes
`define FANP_RESP_OKAY      2'h0
`define FANP_RESP_SLVERR    2'h2

`endif

// ---- shared/fanp_pkg.sv ----
// fanp_pkg: types shared by the fiber next-page register bank
// assumes fanp_map.svh holds every number; only types live here
package fanp_pkg;

  // register select, one-hot
  typedef enum logic [5:0] {
    FANP_SEL_NONE  = 6'h01,
    FANP_SEL_EXP   = 6'h02,
    FANP_SEL_LOCNP = 6'h04,
    FANP_SEL_LPNP  = 6'h08,
    FANP_SEL_CTRL  = 6'h10,
    FANP_SEL_IRQ   = 6'h20
  } fanp_sel_type;

  // local next-page sequencer, one-hot
  typedef enum logic [2:0] {
    FANP_NP_IDLE   = 3'h1,
    FANP_NP_ACTIVE = 3'h2,
    FANP_NP_DONE   = 3'h4
  } fanp_np_state_type;

endpackage

// ---- logic/fanp_page_capture.sv ----
// fanp_page_capture: holds the last next page received from the partner
// assumes capture is a one-cycle strobe in the aclk domain
`timescale 1ns/1ps
`include "fanp_map.svh"

module fanp_page_capture (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        capture,
  input  wire logic [15:0] page_word,
  output logic      [15:0] page_q
);

  // reserved bit dropped at capture so it always reads zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      page_q <= `FANP_RST_LPNP;
    end else if (ce && capture) begin
      page_q <= page_word & `FANP_LPNP_MASK;
    end
  end

endmodule

// ---- tb/fanp_link_partner.sv ----
// fanp_link_partner: behavioural far end of the link, sends pages and acks
// assumes its tasks are called just after a rising aclk edge
`timescale 1ns/1ps

module fanp_link_partner (
  input  wire logic        aclk,
  input  wire logic        sgmii_mode,
  output logic             page_rx_valid,
  output logic             page_rx_is_base,
  output logic [15:0]      page_rx_word,
  output logic             partner_page_ack
);
  // idle line at time zero
  initial begin
    page_rx_valid = 1'b0;
    page_rx_is_base = 1'b0;
    page_rx_word = 16'h0000;
    partner_page_ack = 1'b0;
  end

  // word line flips to the inverse between pages so a stale word never matches
  task automatic send_page(input logic base, input logic [15:0] w);
    logic [15:0] v;
    v = (sgmii_mode && base) ? (w & 16'h7fff) : w; // no more pages in sgmii
    page_rx_valid <= 1'b1;
    page_rx_is_base <= base;
    page_rx_word <= v;
    @(posedge aclk);
    page_rx_valid <= 1'b0;
    page_rx_is_base <= 1'b0;
    page_rx_word <= ~v;
  endtask

  // one-cycle acknowledge of our last page
  task automatic ack();
    partner_page_ack <= 1'b1;
    @(posedge aclk);
    partner_page_ack <= 1'b0;
  endtask
endmodule

// ---- tb/fanp_regs_bench.sv ----
// fanp_regs_bench: self-checking bench for the next-page register bank
// assumes fanp_map.svh on the include path and the link partner model
`timescale 1ns/1ps
`include "fanp_map.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end

module fanp_regs_bench;
  localparam logic [15:0] a_exp = {`FANP_IDX_EXP, 2'b00};
  localparam logic [15:0] a_loc = {`FANP_IDX_LOCNP, 2'b00};
  localparam logic [15:0] a_lp  = {`FANP_IDX_LPNP, 2'b00};
  localparam logic [15:0] a_ctl = {`FANP_IDX_CTRL, 2'b00};
  localparam logic [15:0] a_irq = {`FANP_IDX_IRQ, 2'b00};
  localparam logic [15:0] a_bad = 16'h3024;
  localparam logic [1:0]  ok    = `FANP_RESP_OKAY;
  localparam logic [1:0]  err   = `FANP_RESP_SLVERR;
  logic        aclk, aresetn, ce, sgmii_mode, negotiation_enable_state;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [15:0] s_axi_awaddr, s_axi_araddr, page_rx_word, tx_page_word;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [1:0]  eb;
  logic        page_rx_valid, page_rx_is_base, partner_page_ack;
  logic        advertise_more_pages, tx_page_valid;
  logic [17:0] rq[$];
  logic [1:0]  bq[$];
  logic [15:0] txq[$];
  logic [15:0] w1, w2, nw, e;
  int          n_errors, checks_done, cyc;

  fanp_regs dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .sgmii_mode(sgmii_mode), .negotiation_enable_state(negotiation_enable_state),
    .page_rx_valid(page_rx_valid), .page_rx_is_base(page_rx_is_base),
    .page_rx_word(page_rx_word), .partner_page_ack(partner_page_ack),
    .advertise_more_pages(advertise_more_pages), .tx_page_valid(tx_page_valid),
    .tx_page_word(tx_page_word));

  fanp_link_partner lp (.aclk(aclk), .sgmii_mode(sgmii_mode),
    .page_rx_valid(page_rx_valid), .page_rx_is_base(page_rx_is_base),
    .page_rx_word(page_rx_word), .partner_page_ack(partner_page_ack));

  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  function automatic logic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // write: both channels offered together, each dropped once taken
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [1:0] r);
    logic ga, gw;
    ga = 1'b0;
    gw = 1'b0;
    bq.push_back(r);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= {16'h0000, d};
    while (!(ga && gw)) begin
      @(posedge aclk);
      if (!ga && s_axi_awready) begin
        ga = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!gw && s_axi_wready) begin
        gw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] d, input logic [1:0] r);
    rq.push_back({r, d});
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask

  // monitor: oldest note per answer; unexpected answers count as mismatches
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      if (rq.size() == 0) `CHK(1'b1, 1'b0)
      else begin
        e = rq[0][15:0];
        `CHK(s_axi_rdata, {16'h0000, e})
        `CHK(s_axi_rresp, rq[0][17:16])
        void'(rq.pop_front());
      end
    end
    if (s_axi_bvalid && s_axi_bready) begin
      if (bq.size() == 0) `CHK(1'b1, 1'b0)
      else begin
        // pop once; the compare macro names its arguments twice
        eb = bq.pop_front();
        `CHK(s_axi_bresp, eb)
      end
    end
    if (tx_page_valid) begin
      if (txq.size() == 0) `CHK(1'b1, 1'b0)
      else begin
        e = txq.pop_front();
        `CHK(tx_page_word, e)
      end
    end
  end

  // hang guard, far above the ninety or so cycles of the sequence
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  initial begin
    seed = 32'h4fccc1e6;
    {aresetn, sgmii_mode, negotiation_enable_state} = 3'b000;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 64'h0;
    s_axi_wstrb = 4'h3;
    ce = 1'b1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset values and unmapped access
    rd(a_exp, 16'h0004, ok); // fiber local flag, upper zero
    rd(a_loc, 16'h2001, ok); // local page reset
    rd(a_lp, 16'h0000, ok); // partner page reset
    rd(a_ctl, 16'h0000, ok); // advertise off
    rd(a_irq, 16'h0000, ok); // nothing pending
    rd(a_bad, 16'h0000, err);
    // base page with more pages, then clear on read
    lp.send_page(1'b1, rnd() | 16'h8000);
    rd(a_exp, 16'h000f, ok); // flags set
    rd(a_exp, 16'h000d, ok); // latch cleared by read
    // partner next page
    nw = rnd();
    lp.send_page(1'b0, nw);
    rd(a_lp, nw & 16'hbfff, ok); // fields as received
    rd(a_irq, 16'h0002, ok); // pending flag
    rd(a_irq, 16'h0000, ok); // cleared by read
    rd(a_exp, 16'h000f, ok); // next page latches too
    // local page write, bits 14 and 11 must not take
    w1 = rnd() | 16'hc800;
    wr(a_loc, w1, ok);
    rd(a_loc, w1 & 16'hb7ff, ok); // writable fields
    wr(a_exp, 16'hffff, ok);
    rd(a_exp, 16'h000d, ok); // status ignores writes
    wr(a_bad, 16'hffff, err);
    wr(a_ctl, 16'h8000, ok);
    @(posedge aclk);
    `CHK(advertise_more_pages, 1'b1) // advertise output
    rd(a_ctl, 16'h8000, ok); // advertise bit
    // page sending with toggle
    txq.push_back(w1 & 16'hb7ff); // first page toggle low
    lp.ack();
    @(posedge aclk);
    rd(a_loc, (w1 & 16'hb7ff) | 16'h0800, ok); // toggle flipped
    txq.push_back((w1 & 16'hb7ff) | 16'h0800); // second page toggle high
    lp.ack();
    w2 = rnd() & 16'h37ff;
    wr(a_loc, w2, ok);
    txq.push_back(w2); // last page
    lp.ack();
    repeat (2) @(posedge aclk);
    lp.ack();
    repeat (3) @(posedge aclk);
    `CHK(txq.size(), 0) // no page after the last one
    // negotiation enable clears partner flags and toggle
    negotiation_enable_state <= 1'b1;
    @(posedge aclk);
    negotiation_enable_state <= 1'b0;
    @(posedge aclk);
    rd(a_exp, 16'h0004, ok); // partner flags cleared
    rd(a_loc, w2, ok); // toggle back to zero
    // sgmii: no local next page, partner sends none
    sgmii_mode <= 1'b1;
    @(posedge aclk);
    lp.send_page(1'b1, 16'hffff);
    rd(a_exp, 16'h0003, ok); // sgmii flags
    // clock enable low: a page on the line must leave every flag alone
    ce <= 1'b0;
    lp.send_page(1'b1, rnd());
    ce <= 1'b1;
    rd(a_exp, 16'h0001, ok); // frozen, nothing latched
    end_sim();
  end
endmodule
